// file: rtl/sotc_pkg.sv
// Constants for the stimulus override and trigger control block
package sotc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_PORT_OVR  = 12'h000;
    localparam logic [11:0] OFF_MAST_OVR  = 12'h004;
    localparam logic [11:0] OFF_TRIGGER_LOCATION_CSR  = 12'h008;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SEL_LSB      = 15;
    localparam int SEL_W        = 17;
    localparam int IDX_W_MAX    = 16;
    localparam int POS_OVR_TS   = 2;
    localparam int POS_MAST_EN  = 0;
    localparam int POS_DIR_EN   = 4;
    localparam int POS_TE_EN    = 3;
    localparam int POS_TRG_CLR  = 2;
    localparam int POS_TRG_OCC  = 1;
    localparam int POS_SHOT     = 0;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SOTC_OVR_OFF   = 2'h0,
        SOTC_OVR_GUAR  = 2'h1,
        SOTC_OVR_INVAR = 2'h2,
        SOTC_OVR_RSVD  = 2'h3
    } sotc_ovr_e;

    localparam logic [6:0]       TRIGGER_LOCATION_SRC_ID = 7'h7d;
    localparam logic [SEL_W-1:0] SEL_RESET   = 17'h00000;
    localparam logic             BIT_RESET   = 1'h0;
    localparam logic [31:0]      WORD_ZERO   = 32'h00000000;

endpackage : sotc_pkg

// file: rtl/sotc_ctrl.sv
// Stimulus override and trigger control block with APB register slave
`timescale 1ns/1ps
`default_nettype none

module sotc_ctrl #(
    parameter int PORT_IDX_W = 16,
    parameter int MAST_IDX_W = 16
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sp_wr_valid,
    input  wire logic [PORT_IDX_W-1:0] sp_wr_port,
    input  wire logic [MAST_IDX_W-1:0] sp_wr_master,
    input  wire logic                  sp_wr_port_enabled,
    input  wire logic                  sp_wr_trigger_location_enabled,
    input  wire logic                  sp_wr_trigger_location_location,
    input  wire logic                  sp_wr_makes_trace,
    output logic                       ovr_guaranteed,
    output logic                       ovr_invariant,
    output logic                       ovr_timestamp_req,
    output logic                       trigger_location_emit,
    output logic      [6:0]            trigger_location_source_id
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (PORT_IDX_W < 1 || PORT_IDX_W > sotc_pkg::IDX_W_MAX) begin : g_bad_port
        $error("PORT_IDX_W must be 1 to 16");
    end
    if (MAST_IDX_W < 1 || MAST_IDX_W > sotc_pkg::IDX_W_MAX) begin : g_bad_mast
        $error("MAST_IDX_W must be 1 to 16");
    end
    if (sotc_pkg::SEL_W != sotc_pkg::IDX_W_MAX + 1) begin : g_bad_sel
        $error("Select field must be one bit wider than the index");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [sotc_pkg::SEL_W-1:0] port_select_mask;
        sotc_pkg::sotc_ovr_e        override_mode;
        logic                       timestamp_override;
        logic [sotc_pkg::SEL_W-1:0] master_select_mask;
        logic                       master_select_enable;
        logic                       direct_trigger_id_enable;
        logic                       monitored_trigger_id_enable;
        logic                       trigger_shot_mode;
        logic                       trigger_occurred;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       slverr;
        logic                       guar;
        logic                       invar;
        logic                       ts_req;
        logic                       emit;
        logic [6:0]                 src_id;
    } sotc_state_s;

    sotc_state_s state_q;
    sotc_state_s state_d;

    // ----------------------------------------------------------------
    // Implemented select bits
    // ----------------------------------------------------------------
    // Bits above the implemented index width stay zero
    logic [sotc_pkg::SEL_W-1:0] port_impl;
    logic [sotc_pkg::SEL_W-1:0] mast_impl;

    for (genvar g = 0; g < sotc_pkg::SEL_W; g++) begin : g_impl
        assign port_impl[g] = (g <= PORT_IDX_W);
        assign mast_impl[g] = (g <= MAST_IDX_W);
    end

    // ----------------------------------------------------------------
    // Power-of-two block mask match
    // ----------------------------------------------------------------
    function automatic logic sotc_sel_match(
        input logic [sotc_pkg::SEL_W-1:0]     sel,
        input logic [sotc_pkg::IDX_W_MAX-1:0] idx
    );
        logic found;
        logic hit;
        int   n;
        found = 1'b0;
        hit   = 1'b1;
        n     = 0;
        for (int i = 0; i < sotc_pkg::SEL_W; i++) begin
            if (!found && sel[i]) begin
                found = 1'b1;
                n     = i;
            end
        end
        for (int j = 0; j < sotc_pkg::IDX_W_MAX; j++) begin
            if (j >= n && idx[j] != sel[j+1]) begin
                hit = 1'b0;
            end
        end
        // Top bit alone leaves nothing to compare: all selected
        return found & hit;
    endfunction : sotc_sel_match

    // ----------------------------------------------------------------
    // Register address decode
    // ----------------------------------------------------------------
    function automatic logic [2:0] sotc_decode(
        input logic [11:0] addr
    );
        logic [2:0] hit;
        hit = 3'h0;
        if (addr == sotc_pkg::OFF_PORT_OVR) begin
            hit = 3'h1;
        end else if (addr == sotc_pkg::OFF_MAST_OVR) begin
            hit = 3'h2;
        end else if (addr == sotc_pkg::OFF_TRIGGER_LOCATION_CSR) begin
            hit = 3'h4;
        end
        return hit;
    endfunction : sotc_decode

    // ----------------------------------------------------------------
    // Read word assembly
    // ----------------------------------------------------------------
    function automatic logic [31:0] sotc_read_word(
        input sotc_state_s s,
        input logic [2:0]  hit
    );
        logic [31:0] w;
        w = sotc_pkg::WORD_ZERO;
        if (hit[0]) begin
            w[sotc_pkg::SEL_LSB +: sotc_pkg::SEL_W] = s.port_select_mask;
            w[sotc_pkg::POS_OVR_TS]                 = s.timestamp_override;
            w[1:0]                                  = s.override_mode;
        end else if (hit[1]) begin
            w[sotc_pkg::SEL_LSB +: sotc_pkg::SEL_W] = s.master_select_mask;
            w[sotc_pkg::POS_MAST_EN]                = s.master_select_enable;
        end else if (hit[2]) begin
            w[sotc_pkg::POS_DIR_EN]  = s.direct_trigger_id_enable;
            w[sotc_pkg::POS_TE_EN]   = s.monitored_trigger_id_enable;
            w[sotc_pkg::POS_TRG_OCC] = s.trigger_occurred;
            w[sotc_pkg::POS_SHOT]    = s.trigger_shot_mode;
        end
        return w;
    endfunction : sotc_read_word

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [sotc_pkg::IDX_W_MAX-1:0] port_idx;
    logic [sotc_pkg::IDX_W_MAX-1:0] mast_idx;
    logic                           setup;
    logic                           wr_acc;
    logic                           port_hit;
    logic                           mast_hit;
    logic                           trigger_location_cause;
    logic                           clr_req;
    logic [2:0]                     reg_hit;
    logic                           mode_guar;
    logic                           mode_invar;
    logic                           ovr_base;

    always_comb begin
        state_d    = state_q;
        port_idx   = sotc_pkg::IDX_W_MAX'(sp_wr_port);
        mast_idx   = sotc_pkg::IDX_W_MAX'(sp_wr_master);
        setup      = psel & ~penable;
        wr_acc     = psel & penable & pready & pwrite;
        clr_req    = 1'b0;
        reg_hit    = sotc_decode(paddr);
        mode_guar  = (state_q.override_mode == sotc_pkg::SOTC_OVR_GUAR);
        mode_invar = (state_q.override_mode == sotc_pkg::SOTC_OVR_INVAR);

        // ----------------------------------------------------------------
        // Register writes
        // ----------------------------------------------------------------
        if (wr_acc) begin
            if (reg_hit[0]) begin
                state_d.port_select_mask =
                    pwdata[sotc_pkg::SEL_LSB +: sotc_pkg::SEL_W] & port_impl;
                state_d.timestamp_override = pwdata[sotc_pkg::POS_OVR_TS];
                state_d.override_mode = sotc_pkg::sotc_ovr_e'(pwdata[1:0]);
            end else if (reg_hit[1]) begin
                state_d.master_select_mask =
                    pwdata[sotc_pkg::SEL_LSB +: sotc_pkg::SEL_W] & mast_impl;
                state_d.master_select_enable = pwdata[sotc_pkg::POS_MAST_EN];
            end else if (reg_hit[2]) begin
                state_d.direct_trigger_id_enable    = pwdata[sotc_pkg::POS_DIR_EN];
                state_d.monitored_trigger_id_enable = pwdata[sotc_pkg::POS_TE_EN];
                state_d.trigger_shot_mode           = pwdata[sotc_pkg::POS_SHOT];
                clr_req = pwdata[sotc_pkg::POS_TRG_CLR] & state_q.trigger_shot_mode;
            end
        end

        // ----------------------------------------------------------------
        // Override decisions for the current stimulus write
        // ----------------------------------------------------------------
        port_hit = sotc_sel_match(state_q.port_select_mask, port_idx);
        mast_hit = ~state_q.master_select_enable
                 | sotc_sel_match(state_q.master_select_mask, mast_idx);
        ovr_base = sp_wr_valid & port_hit & mast_hit;
        state_d.guar  = ovr_base & mode_guar;
        state_d.invar = ovr_base & mode_invar;
        state_d.ts_req = sp_wr_valid & sp_wr_makes_trace
                       & state_q.timestamp_override;

        // ----------------------------------------------------------------
        // Trigger emission
        // ----------------------------------------------------------------
        trigger_location_cause = sp_wr_valid & sp_wr_port_enabled
                   & ((sp_wr_trigger_location_location & state_q.direct_trigger_id_enable)
                    | (sp_wr_trigger_location_enabled & state_q.monitored_trigger_id_enable));
        state_d.emit = trigger_location_cause
                     & ~(state_q.trigger_shot_mode & state_q.trigger_occurred);
        state_d.src_id = state_d.emit ? sotc_pkg::TRIGGER_LOCATION_SRC_ID : 7'h00;

        // ----------------------------------------------------------------
        // Status: set wins over clear
        // ----------------------------------------------------------------
        if (clr_req) begin
            state_d.trigger_occurred = 1'b0;
        end
        if (state_d.trigger_shot_mode == 1'b0) begin
            state_d.trigger_occurred = 1'b0;
        end else if (state_q.trigger_shot_mode & trigger_location_cause) begin
            state_d.trigger_occurred = 1'b1;
        end

        // ----------------------------------------------------------------
        // APB answer, one cycle after setup
        // ----------------------------------------------------------------
        state_d.ready  = setup;
        state_d.slverr = 1'b0;
        state_d.rdata  = sotc_pkg::WORD_ZERO;
        if (setup) begin
            state_d.rdata  = sotc_read_word(state_q, reg_hit);
            state_d.slverr = (reg_hit == 3'h0);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q.port_select_mask            <= sotc_pkg::SEL_RESET;
            state_q.override_mode               <= sotc_pkg::SOTC_OVR_OFF;
            state_q.timestamp_override          <= sotc_pkg::BIT_RESET;
            state_q.master_select_mask          <= sotc_pkg::SEL_RESET;
            state_q.master_select_enable        <= sotc_pkg::BIT_RESET;
            state_q.direct_trigger_id_enable    <= sotc_pkg::BIT_RESET;
            state_q.monitored_trigger_id_enable <= sotc_pkg::BIT_RESET;
            state_q.trigger_shot_mode           <= sotc_pkg::BIT_RESET;
            state_q.trigger_occurred            <= sotc_pkg::BIT_RESET;
            state_q.rdata                       <= sotc_pkg::WORD_ZERO;
            state_q.ready                       <= 1'b0;
            state_q.slverr                      <= 1'b0;
            state_q.guar                        <= 1'b0;
            state_q.invar                       <= 1'b0;
            state_q.ts_req                      <= 1'b0;
            state_q.emit                        <= 1'b0;
            state_q.src_id                      <= 7'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata            = state_q.rdata;
    assign pready            = state_q.ready;
    assign pslverr           = state_q.slverr;
    assign ovr_guaranteed    = state_q.guar;
    assign ovr_invariant     = state_q.invar;
    assign ovr_timestamp_req = state_q.ts_req;
    assign trigger_location_emit         = state_q.emit;
    assign trigger_location_source_id    = state_q.src_id;

endmodule : sotc_ctrl

`default_nettype wire

// file: testbench/sotc_chk.sv
// Assertion checker for the stimulus override and trigger control block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module sotc_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       sp_wr_valid,
    input wire logic       sp_wr_port_enabled,
    input wire logic       sp_wr_makes_trace,
    input wire logic       ovr_guaranteed,
    input wire logic       ovr_invariant,
    input wire logic       ovr_timestamp_req,
    input wire logic       trigger_location_emit,
    input wire logic [6:0] trigger_location_source_id
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_guar_cause: assert property (ovr_guaranteed |-> $past(sp_wr_valid))
        else $error("guaranteed flag without a write");
    a_mode_excl: assert property (ovr_guaranteed |-> !ovr_invariant)
        else $error("both override modes at once");
    a_invar_cause: assert property (ovr_invariant |-> $past(sp_wr_valid))
        else $error("invariant flag without a write");
    a_ts_traced: assert property (ovr_timestamp_req |-> $past(sp_wr_valid && sp_wr_makes_trace))
        else $error("timestamp request without traced write");
    a_ts_untraced: assert property (sp_wr_valid && !sp_wr_makes_trace |=> !ovr_timestamp_req)
        else $error("timestamp request for untraced write");
    a_trigger_location_disabled: assert property (sp_wr_valid && !sp_wr_port_enabled |=> !trigger_location_emit)
        else $error("trigger from a disabled port");
    a_trigger_location_id: assert property (trigger_location_emit |-> trigger_location_source_id == 7'h7d)
        else $error("wrong trigger source id");
    a_id_idle: assert property (!trigger_location_emit |-> trigger_location_source_id == 7'h00)
        else $error("source id shown without trigger");
endmodule : sotc_chk

bind sotc_ctrl sotc_chk chk (.*);
`default_nettype wire

// file: testbench/sotc_sp_model.sv
// Bus master model that writes to stimulus ports
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Stimulus port writer
// ----------------------------------------------------------------
module sotc_sp_model (
    input  wire logic        pclk,
    output var  logic        sp_wr_valid,
    output var  logic [15:0] sp_wr_port,
    output var  logic [15:0] sp_wr_master,
    output var  logic        sp_wr_port_enabled,
    output var  logic        sp_wr_trigger_location_enabled,
    output var  logic        sp_wr_trigger_location_location,
    output var  logic        sp_wr_makes_trace
);
    initial begin
        sp_wr_valid = 1'b0;
        sp_wr_port = 16'h0000;
        sp_wr_master = 16'h0000;
        {sp_wr_port_enabled, sp_wr_trigger_location_enabled, sp_wr_trigger_location_location, sp_wr_makes_trace} = 4'h0;
    end
    // One write for one cycle, then fields scrambled
    task automatic wr(input logic [15:0] p, input logic [15:0] m, input logic [3:0] f);
        @(posedge pclk);
        sp_wr_valid <= 1'b1;
        sp_wr_port <= p;
        sp_wr_master <= m;
        {sp_wr_port_enabled, sp_wr_trigger_location_enabled, sp_wr_trigger_location_location, sp_wr_makes_trace} <= f;
        @(posedge pclk);
        sp_wr_valid <= 1'b0;
        sp_wr_port <= ~p;
        sp_wr_master <= ~m;
        {sp_wr_port_enabled, sp_wr_trigger_location_enabled, sp_wr_trigger_location_location, sp_wr_makes_trace} <= ~f;
    endtask : wr
endmodule : sotc_sp_model
`default_nettype wire

// file: testbench/test_stimulus_override_trigger_ctrl.sv
// Testbench for the stimulus override and trigger control block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module test_stimulus_override_trigger_ctrl;
    localparam logic [11:0] PO = sotc_pkg::OFF_PORT_OVR;
    localparam logic [11:0] MO = sotc_pkg::OFF_MAST_OVR;
    localparam logic [11:0] TC = sotc_pkg::OFF_TRIGGER_LOCATION_CSR;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, rerr;
    logic        sp_wr_valid, sp_wr_port_enabled, sp_wr_trigger_location_enabled;
    logic        sp_wr_trigger_location_location, sp_wr_makes_trace;
    logic [15:0] sp_wr_port, sp_wr_master;
    logic        ovr_guaranteed, ovr_invariant, ovr_timestamp_req, trigger_location_emit;
    logic [6:0]  trigger_location_source_id;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    sotc_ctrl uut (.*);
    sotc_sp_model sp_model (.*);

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check("register read", rdat, exp);
    endtask : rc
    // Flags {enabled, trigger_location enabled, location, trace}; result {guar, invar, ts, trigger_location}
    task automatic sp(input logic [15:0] p, input logic [15:0] m, input logic [3:0] f,
                      input logic [3:0] exp);
        sp_model.wr(p, m, f);
        #1;
        check("outputs", {21'h0, trigger_location_source_id, ovr_guaranteed, ovr_invariant,
                          ovr_timestamp_req, trigger_location_emit},
              {21'h0, (exp[0] ? sotc_pkg::TRIGGER_LOCATION_SRC_ID : 7'h00), exp});
    endtask : sp

    task automatic t_regs();
        rc(PO, 32'h00000000);
        rc(MO, 32'h00000000);
        rc(TC, 32'h00000000);
        apb(1'b0, 12'h00c, 32'h00000000);
        check("unmapped error", {31'h0, rerr}, 32'h00000001);
        wr(PO, 32'hffffffff);
        rc(PO, 32'hffff8007);
        wr(MO, 32'hffffffff);
        rc(MO, 32'hffff8001);
        wr(TC, 32'hfffffffb); // No clear while multi-shot
        rc(TC, 32'h00000019);
        wr(TC, 32'h00000000);
        wr(MO, 32'h00000000);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_override();
        wr(PO, {16'd5, 1'b1, 15'h0001}); // Nonzero, in range
        sp(16'd5, 16'd0, 4'b1000, 4'b1000);
        sp(16'd4, 16'd0, 4'b1000, 4'b0000);
        wr(PO, {17'h00060, 15'h0002});
        sp(16'd40, 16'd0, 4'b1000, 4'b0100);
        sp(16'd64, 16'd0, 4'b1000, 4'b0000);
        wr(PO, {17'h10000, 15'h0001});
        sp(16'hffff, 16'd0, 4'b1000, 4'b1000);
        wr(PO, {17'h10000, 15'h0003});
        sp(16'd3, 16'd0, 4'b1000, 4'b0000);
        wr(PO, {17'h10000, 15'h0004});
        sp(16'd3, 16'd0, 4'b1001, 4'b0010);
        sp(16'd3, 16'd0, 4'b1000, 4'b0000);
        $display("t_override done");
    endtask : t_override
    task automatic t_master();
        wr(PO, {17'h10000, 15'h0005});
        wr(MO, {16'd1, 1'b1, 15'h0001}); // Nonzero master select
        sp(16'd7, 16'd1, 4'b1001, 4'b1010);
        sp(16'd7, 16'd2, 4'b1001, 4'b0010);
        wr(MO, {17'h10000, 15'h0001});
        sp(16'd7, 16'd9, 4'b1000, 4'b1000);
        wr(MO, {16'd1, 1'b1, 15'h0000});
        sp(16'd7, 16'd2, 4'b1000, 4'b1000);
        wr(PO, 32'h00000000);
        $display("t_master done");
    endtask : t_master
    task automatic t_trigger();
        wr(TC, 32'h00000010);
        sp(16'd1, 16'd0, 4'b1010, 4'b0001);
        sp(16'd1, 16'd0, 4'b0010, 4'b0000);
        sp(16'd1, 16'd0, 4'b1100, 4'b0000);
        wr(TC, 32'h00000018);
        sp(16'd1, 16'd0, 4'b1100, 4'b0001);
        sp(16'd1, 16'd0, 4'b1100, 4'b0001);
        rc(TC, 32'h00000018);
        wr(TC, 32'h00000019);
        sp(16'd1, 16'd0, 4'b1100, 4'b0001);
        sp(16'd1, 16'd0, 4'b1010, 4'b0000);
        rc(TC, 32'h0000001b);
        wr(TC, 32'h00000019);
        rc(TC, 32'h0000001b);
        wr(TC, 32'h0000001d);
        rc(TC, 32'h00000019);
        sp(16'd1, 16'd0, 4'b1010, 4'b0001);
        $display("t_trigger done");
    endtask : t_trigger

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_override();
        t_master();
        t_trigger();
        results();
    end
endmodule : test_stimulus_override_trigger_ctrl
`default_nettype wire
